// ---- hw/gate_spi_params.svh ----
// Constants for the gate driver serial slave port and its register bus
`ifndef GATE_SPI_PARAMS_SVH
`define GATE_SPI_PARAMS_SVH

`define FRAME_LEN 5'h10
`define CNT_MAX 5'h1F
`define RW_WRITE 1'b0
`define STATUS_ADDR 4'h0
`define FAULT_WORD 16'h8000
`define PIN_RST 4'hA
`define CTRL_RST 1'b1

`define OFS_CTRL 12'h000
`define OFS_LINK 12'h004
`define OFS_IRQ_STAT 12'h008
`define OFS_IRQ_CLR 12'h00C
`define OFS_IRQ_EN 12'h010
`define OFS_LAST 12'h014
`define WIN_PAGE 6'h01

`define EV_OK 0
`define EV_ERR 1
`define EV_WR 2
`define EV_GATE 3
`define EV_N 4

`endif

// ---- hw/gate_spi_pkg.sv ----
// Types shared by the gate driver serial slave port
package gate_spi_pkg;

  typedef struct packed {
    logic rw;
    logic [3:0] addr;
    logic [10:0] data;
  } spi_cmd_type;

  typedef struct packed {
    logic fault;
    logic [3:0] addr;
    logic [10:0] data;
  } spi_resp_type;

  typedef logic [15:0][10:0] reg_file_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_FRAME = 2'b10
  } frame_state_type;

endpackage

// ---- hw/gate_driver_spi_slave.sv ----
// Serial slave port of a three-phase gate driver with an APB control face
//
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "gate_spi_params.svh"

module gate_driver_spi_slave (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic sdi,
  input wire logic gate_enable,
  input wire logic [10:0] fault_in,
  output logic sdo_out,
  output logic sdo_oe_n,
  output logic irq,
  output gate_spi_pkg::reg_file_type reg_image
);

  // Reset levels match the idle pins: gate high, select high, clock low,
  // so leaving reset with the gate already enabled is not taken as a gate rise
  localparam logic [3:0] PIN_RST = `PIN_RST;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: {gate_enable, sclk, chip_select_n, sdi}
  logic [3:0] pin_raw;
  logic [3:0] s1_reg;
  logic [3:0] s2_reg;
  logic [3:0] s3_reg;
  logic [3:0] filt_reg;
  logic [3:0] filt_d_reg;

  // Three stages against metastability; only the second stage reads the first
  assign pin_raw = {gate_enable, sclk, chip_select_n, sdi};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= PIN_RST;
      s2_reg <= PIN_RST;
      s3_reg <= PIN_RST;
      filt_d_reg <= PIN_RST;
    end else if (ce) begin
      s1_reg <= pin_raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      filt_d_reg <= filt_reg;
    end
  end

  // A level only counts once two later stages agree, so one noisy sample is dropped
  genvar gp;
  generate
    for (gp = 0; gp < 4; gp = gp + 1) begin : g_filt
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          filt_reg[gp] <= PIN_RST[gp];
        end else if (ce && (s2_reg[gp] == s3_reg[gp])) begin
          filt_reg[gp] <= s3_reg[gp];
        end
      end
    end
  endgenerate

  // Filtered pin levels and their one-cycle-old copies give clean edge strobes
  logic gate_f;
  logic sclk_f;
  logic cs_f;
  logic sdi_f;
  logic ctrl_en_reg;
  logic link_en;
  logic gate_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic sel_fall;

  assign gate_f = filt_reg[3];
  assign sclk_f = filt_reg[2];
  assign cs_f = filt_reg[1];
  assign sdi_f = filt_reg[0];
  assign link_en = gate_f & ctrl_en_reg;
  assign gate_rise = gate_f & ~filt_d_reg[3];
  assign sclk_rise = sclk_f & ~filt_d_reg[2];
  assign sclk_fall = ~sclk_f & filt_d_reg[2];
  // Select edges only count while the link is enabled, so no frame can start
  // in low-power mode and be taken for a fresh one later
  assign sel_fall = ~cs_f & filt_d_reg[1] & link_en;

  ////////////////////////////////////////////////////////////////////////////
  // Frame sequencing
  gate_spi_pkg::frame_state_type state_reg;
  gate_spi_pkg::frame_state_type state_next;
  logic in_frame;
  logic frame_end;
  logic frame_valid;
  logic start_low_reg;
  logic [4:0] bit_cnt_reg;
  logic [15:0] rx_reg;
  gate_spi_pkg::spi_cmd_type rx_cmd;

  assign in_frame = (state_reg == gate_spi_pkg::ST_FRAME);
  // Select rising or the link being switched off both end a frame
  assign frame_end = in_frame & (cs_f | ~link_en);
  // command and data fields
  // The struct view gives rw in bit 15, address 14:11, data 10:0
  assign rx_cmd = rx_reg;
  // Any bad property of a frame raises the fault flag and the frame error event and drops the write
  // exact count and clean edges
  assign frame_valid = frame_end & link_en & (bit_cnt_reg == `FRAME_LEN)
    & start_low_reg & ~sclk_f;

  // Two states: waiting for select, inside a frame
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      gate_spi_pkg::ST_IDLE: begin
        if (sel_fall) begin
          state_next = gate_spi_pkg::ST_FRAME;
        end
      end
      gate_spi_pkg::ST_FRAME: begin
        if (frame_end) begin
          state_next = gate_spi_pkg::ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= gate_spi_pkg::ST_IDLE;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_low_reg <= 1'b0;
    end else if (ce && sel_fall) begin
      start_low_reg <= ~sclk_f;
    end
  end

  // Counter saturates so a long frame never wraps back to a legal count
  // no bit timeout
  // A stalled clock inside a frame is legal, so nothing here times out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_cnt_reg <= 5'h00;
      rx_reg <= 16'h0000;
    end else if (ce) begin
      if (sel_fall) begin
        bit_cnt_reg <= 5'h00;
      end else if (in_frame && sclk_fall) begin
        rx_reg <= {rx_reg[14:0], sdi_f};
        if (bit_cnt_reg != `CNT_MAX) begin
          bit_cnt_reg <= bit_cnt_reg + 5'h01;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file, status in entry zero
  gate_spi_pkg::reg_file_type regs_reg;
  logic spi_wr;

  assign spi_wr = frame_valid & (rx_cmd.rw == `RW_WRITE);

  // Entry zero collects fault_in every cycle and is never written from the link;
  // a fault that is still present keeps its bit set in the gate rise cycle itself
  // Writes to entry zero are dropped: it only reports faults
  genvar gr;
  generate
    for (gr = 0; gr < 16; gr = gr + 1) begin : g_regs
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          regs_reg[gr] <= 11'h000;
        end else if (ce) begin
          if (gr == `STATUS_ADDR) begin
            regs_reg[gr] <= (gate_rise ? 11'h000 : regs_reg[gr]) | fault_in;
          end else if (spi_wr && (rx_cmd.addr == gr)) begin
            regs_reg[gr] <= rx_cmd.data;
          end
        end
      end
    end
  endgenerate

  // Copy for the gate driver core, one cycle behind the register file
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_image <= '0;
    end else if (ce) begin
      reg_image <= regs_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Response selection and shifting
  logic pend_fault_reg;
  logic [3:0] pend_addr_reg;
  logic [15:0] last_cmd_reg;
  gate_spi_pkg::spi_resp_type resp_word;
  logic [15:0] tx_reg;

  // The response is chosen at frame end and held until the next select fall or gate rise,
  // so a long gap between frames changes which register is sent only if the gate rises in it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_fault_reg <= 1'b0;
      pend_addr_reg <= `STATUS_ADDR;
      last_cmd_reg <= 16'h0000;
    end else if (ce) begin
      if (frame_end) begin
        pend_fault_reg <= ~frame_valid;
        // read target / write returns status
        pend_addr_reg <= (rx_cmd.rw == `RW_WRITE) ? `STATUS_ADDR : rx_cmd.addr;
        if (frame_valid) begin
          last_cmd_reg <= rx_reg;
        end
      end else if (gate_rise) begin
        // A gate rise forgets the old command and answers with status
        pend_fault_reg <= 1'b0;
        pend_addr_reg <= `STATUS_ADDR;
      end
    end
  end

  // layout / fault word
  // Register data follows the live register and is sampled at select fall
  always_comb begin
    resp_word = `FAULT_WORD;
    if (!pend_fault_reg) begin
      resp_word.fault = 1'b0;
      resp_word.addr = pend_addr_reg;
      resp_word.data = regs_reg[pend_addr_reg];
    end
  end

  // The first bit is driven at select fall and repeated by the first clock rise,
  // so after clock rise k the pin shows bit 16-k
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_reg <= 16'h0000;
      sdo_out <= 1'b0;
      sdo_oe_n <= 1'b1;
    end else if (ce) begin
      if (sel_fall) begin
        tx_reg <= resp_word;
        sdo_out <= resp_word[15];
        sdo_oe_n <= 1'b0;
      end else if (!in_frame || frame_end) begin
        sdo_oe_n <= 1'b1;
      end else if (sclk_rise) begin
        sdo_out <= tx_reg[15];
        tx_reg <= {tx_reg[14:0], 1'b0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave, one wait state so every answer comes from a flop
  logic apb_acc;
  logic apb_done;
  logic apb_wr;
  logic rd_hit;
  logic [31:0] rd_data;
  logic [`EV_N-1:0] irq_stat_reg;
  logic [`EV_N-1:0] irq_en_reg;
  logic [`EV_N-1:0] ev;
  logic [`EV_N-1:0] clr_mask;

  assign apb_acc = psel & penable;
  assign apb_done = apb_acc & pready;
  assign apb_wr = apb_done & pwrite;

  // Serial registers sit in a window of sixteen words; everything else is decoded
  // by exact address, and an unmapped access answers with an error
  always_comb begin
    rd_hit = 1'b1;
    rd_data = 32'h0000_0000;
    if (paddr[11:6] == `WIN_PAGE) begin
      rd_data = {21'h000000, regs_reg[paddr[5:2]]};
    end else begin
      case (paddr)
        `OFS_CTRL: rd_data = {31'h0000_0000, ctrl_en_reg};
        `OFS_LINK: rd_data = {23'h000000, bit_cnt_reg, in_frame, gate_f, cs_f, sclk_f};
        `OFS_IRQ_STAT: rd_data = {28'h0000000, irq_stat_reg};
        `OFS_IRQ_CLR: rd_data = 32'h0000_0000;
        `OFS_IRQ_EN: rd_data = {28'h0000000, irq_en_reg};
        `OFS_LAST: rd_data = {16'h0000, last_cmd_reg};
        default: rd_hit = 1'b0;
      endcase
    end
  end

  // Read data is captured in the wait state, so prdata stands with pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      pready <= apb_acc & ~pready;
      pslverr <= apb_acc & ~pready & ~rd_hit;
      if (apb_acc && !pready && !pwrite) begin
        prdata <= rd_data;
      end
    end
  end

  // Writes to read-only or unmapped words change nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_en_reg <= `CTRL_RST;
      irq_en_reg <= '0;
    end else if (ce && apb_wr) begin
      if (paddr == `OFS_CTRL) begin
        ctrl_en_reg <= pwdata[0];
      end
      if (paddr == `OFS_IRQ_EN) begin
        irq_en_reg <= pwdata[`EV_N-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: a new event beats a clear in the same cycle
  // Bits: frame ok, frame error, serial write, gate rise
  always_comb begin
    ev = '0;
    ev[`EV_OK] = frame_valid;
    ev[`EV_ERR] = frame_end & ~frame_valid;
    ev[`EV_WR] = spi_wr;
    ev[`EV_GATE] = gate_rise;
    clr_mask = '0;
    if (apb_wr && (paddr == `OFS_IRQ_CLR)) begin
      clr_mask = pwdata[`EV_N-1:0];
    end
  end

  // irq lags the status by one cycle because it comes from its own flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg <= '0;
      irq <= 1'b0;
    end else if (ce) begin
      irq_stat_reg <= (irq_stat_reg & ~clr_mask) | ev;
      irq <= |(irq_stat_reg & irq_en_reg);
    end
  end

endmodule
`default_nettype wire

// ---- verification/gate_spi_properties.sv ----
// Concurrent checks on the gate driver serial slave port
`timescale 1ns/1ps
`default_nettype none
module gate_spi_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic gate_enable,
  input wire logic [10:0] fault_in,
  input wire logic sdo_oe_n,
  input wire logic sdo_out,
  input wire gate_spi_pkg::reg_file_type reg_image
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  deselect_hiz_a: assert property (chip_select_n [*8] |-> sdo_oe_n)
    else $error("sdo driven while deselected");
  gate_low_hiz_a: assert property ((!gate_enable) [*8] |-> sdo_oe_n)
    else $error("sdo driven while gate is low");
  select_drive_a: assert property (
    chip_select_n ##1 (!chip_select_n && gate_enable && !sclk) [*8] |-> !sdo_oe_n)
    else $error("sdo not enabled after select fall");
  sdo_hold_a: assert property ((!sclk && !chip_select_n) [*8] |=> $stable(sdo_out))
    else $error("sdo moved without a clock rise");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  wait_state_a: assert property (psel && penable && !pready |=> pready)
    else $error("pready not after one wait state");
  slverr_qual_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  status_sticky_a: assert property (gate_enable [*8] |=> !$fell(|reg_image[0]))
    else $error("status dropped while gate high");
  gate_clear_a: assert property (
    $rose(gate_enable) ##1 (fault_in == 11'h000) [*8] |-> reg_image[0] == 11'h000)
    else $error("status kept after gate rise");
  cover property ($fell(chip_select_n));
  cover property (pslverr);
  cover property ($rose(gate_enable));
endmodule
bind gate_driver_spi_slave gate_spi_properties gate_spi_properties_inst (.pclk, .presetn,
  .psel, .penable, .pready, .pslverr, .sclk, .chip_select_n, .gate_enable, .fault_in,
  .sdo_oe_n, .sdo_out, .reg_image);
`default_nettype wire

// ---- verification/spi_master_model.sv ----
// Behavioural serial master facing the slave port
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
  output logic sclk,
  output logic chip_select_n,
  output logic sdi,
  input wire logic sdo_line
);
  initial begin
    sclk = 1'b0;
    chip_select_n = 1'b1;
    sdi = 1'b1;
  end
  // Sends n bits, a pause after bit 8 when asked; reply bits taken before each next rise
  task automatic xfer(input logic [15:0] w, input int n, input bit pause,
      output logic [15:0] r);
    logic [16:0] sh;
    // Step off the bench clock edge so the pins never move as it samples them
    #5;
    sh = {w, 1'b0};
    r = 16'h0000;
    chip_select_n = 1'b0;
    #160;
    for (int k = 1; k <= n; k++) begin
      sclk = 1'b1;
      sdi = sh[16];
      sh = sh << 1;
      #80 sclk = 1'b0;
      #80 if (k <= 16) r[16-k] = sdo_line;
      if (pause && k == 8) #2000;
    end
    #80 chip_select_n = 1'b1;
    // Released line must not look like valid data
    sdi = ~sdi;
    // Select stays high long enough for the slave's filter to see the frame end,
    // and the call spacing stays a whole number of bench clocks
    #175;
  endtask
endmodule
`default_nettype wire

// ---- verification/gate_driver_spi_slave_tb.sv ----
// Self-checking bench for the gate driver serial slave port
`timescale 1ns/1ps
`default_nettype none
module gate_driver_spi_slave_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, irq;
  logic sclk, chip_select_n, sdi, sdo_out, sdo_oe_n, gate_enable;
  wire sdo_line;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [10:0] fault_in;
  logic [15:0] r;
  gate_spi_pkg::reg_file_type reg_image;
  int mismatches, check_count;
  // No pull on the data line: a released pin reads as high impedance
  assign sdo_line = sdo_oe_n ? 1'bz : sdo_out;
  gate_driver_spi_slave gate_driver_spi_slave_inst (.pclk, .presetn, .ce(1'b1), .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sclk, .chip_select_n,
    .sdi, .gate_enable, .fault_in, .sdo_out, .sdo_oe_n, .irq, .reg_image);
  spi_master_model spi_master_model_inst (.sclk, .chip_select_n, .sdi, .sdo_line);
  always #10 pclk = ~pclk;
  task chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task end_sim;
    if (mismatches == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    // Waits for the answer itself; only the watchdog ends a hung access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task t_regs;
    apb(0, 12'h000, 0);
    chk(q, 32'h0000_0001);
    apb(0, 12'h0FC, 0);
    chk(err, 1'b1);
  endtask
  task t_write_read;
    spi_master_model_inst.xfer(16'h1AA5, 16, 1, r);
    spi_master_model_inst.xfer(16'h9800, 16, 0, r);
    chk(r, 16'h0000);
    spi_master_model_inst.xfer(16'h8000, 16, 0, r);
    chk(r, 16'h1AA5);
    chk(reg_image[3], 11'h2A5);
    apb(0, 12'h04C, 0);
    chk(q, 32'h0000_02A5);
    apb(0, 12'h014, 0);
    chk(q, 32'h0000_8000);
  endtask
  task t_frame_err;
    for (int n = 12; n <= 17; n += 5) begin
      spi_master_model_inst.xfer(16'h2955, n, 0, r);
      spi_master_model_inst.xfer(16'h8000, 16, 0, r);
      chk(r, 16'h8000);
      chk(reg_image[5], 11'h000);
      chk(reg_image[10], 11'h000);
    end
  endtask
  task t_irq;
    apb(0, 12'h008, 0);
    chk(q[2:0], 3'h7);
    apb(1, 12'h010, 0);
    repeat (3) @(posedge pclk);
    chk(irq, 1'b0);
    apb(1, 12'h010, 32'h0000_0002);
    repeat (3) @(posedge pclk);
    chk(irq, 1'b1);
    apb(1, 12'h00C, 32'h0000_000F);
    repeat (3) @(posedge pclk);
    chk(irq, 1'b0);
    apb(0, 12'h008, 0);
    chk(q, 32'h0000_0000);
  endtask
  task t_gate;
    @(posedge pclk);
    fault_in <= 11'h004;
    repeat (4) @(posedge pclk);
    fault_in <= 11'h000;
    spi_master_model_inst.xfer(16'h8000, 16, 0, r);
    spi_master_model_inst.xfer(16'h8000, 16, 0, r);
    chk(r, 16'h0004);
    @(posedge pclk);
    gate_enable <= 1'b0;
    #1000;
    spi_master_model_inst.xfer(16'h8000, 16, 0, r);
    chk(r, 16'hZZZZ);
    @(posedge pclk);
    gate_enable <= 1'b1;
    repeat (10) @(posedge pclk);
    apb(0, 12'h040, 0);
    chk(q, 32'h0000_0000);
  endtask
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    gate_enable = 1'b1;
    fault_in = 11'h000;
    mismatches = 0;
    check_count = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    t_regs;
    t_write_read;
    t_frame_err;
    t_irq;
    t_gate;
    end_sim;
  end
  // Whole run needs about a fifteenth of this span
  initial begin
    #500000;
    mismatches++;
    end_sim;
  end
endmodule
`default_nettype wire
